/* File: hdl/link_capabilities_register.sv */
// Link capabilities register with AXI4-Lite access and L1 exit timing
// How it works
// - Bits 3:0 are a read-only speed field that resets to 1 (2.5 Gbps); 2 means 5 Gbps, others are reserved.
// - Bits 9:4 hold the maximum lane width where 1, 2 and 4 are valid lane counts and other codes are reserved.
// - On the upstream port software may overwrite the width field to train narrower than the physical width.
// - A reserved or invalid width code makes the link train as a single lane.
// - After reset the width field is loaded with the port's physical lane width.
// - Bits 11:10 are fixed at 3, advertising both low-power link states.
// - With separate reference clocks the L0s exit latency in bits 14:12 reads 5.
// - With a common reference clock the L0s exit latency reads 3.
// - The common-clock choice follows bit 6 of the link control register.
// - The L1 exit latency in bits 17:15 resets to 2.
// - Every return from L1 to active finishes within 2.3 microseconds.
// - Bit 18, clock removal tolerance, resets to 0.
// - Bit 19, surprise-down reporting, resets to 1 on downstream ports and 0 upstream.
// - Bit 20, link-active reporting, resets to 1 downstream and stays 0 upstream.
// - Bits 31:24 read the port number.
`include "link_cap_cfg.svh"
module link_capabilities_register #(
	parameter int L1_EXIT_CYCLES = `L1_EXIT_CYCLES
) (
	input  wire logic                      clock,
	input  wire logic                      rst,
	input  wire logic                      is_upstream,
	input  wire logic [7:0]                port_number,
	input  wire link_cap_pkg::lane_width_t phys_width,
	input  wire logic                      l1_exit_req,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [11:0]               s_axi_awaddr,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	input  wire link_cap_pkg::word_t       s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	output link_cap_pkg::axi_resp_t        s_axi_bresp,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	input  wire logic [11:0]               s_axi_araddr,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	output link_cap_pkg::word_t            s_axi_rdata,
	output link_cap_pkg::axi_resp_t        s_axi_rresp,
	output link_cap_pkg::lane_width_t      train_width,
	output logic                           common_clock_config,
	output logic                           l1_exiting,
	output logic                           l1_exit_done
);
	import link_cap_pkg::*;

	if (L1_EXIT_CYCLES < 2 || L1_EXIT_CYCLES > `L1_EXIT_CYCLES) begin : g_bad_cycles
		$error("L1_EXIT_CYCLES out of range");
	end

	// Register fields
	logic        init_q, init_d;
	lane_width_t width_q, width_d;
	logic [2:0]  l1_lat_q, l1_lat_d;
	logic        clkrm_q, clkrm_d;
	logic        sdown_q, sdown_d;
	logic        active_rep_q, active_rep_d;
	logic [7:0]  port_q, port_d;
	logic        upstream_q, upstream_d;
	logic        cmn_clk_q, cmn_clk_d;
	logic        unlock_q, unlock_d;

	// Bus state
	logic        aw_have_q, aw_have_d;
	logic [11:0] aw_addr_q, aw_addr_d;
	logic        w_have_q, w_have_d;
	word_t       w_data_q, w_data_d;
	logic [3:0]  w_strb_q, w_strb_d;
	logic        bvalid_q, bvalid_d;
	axi_resp_t   bresp_q, bresp_d;
	logic        rvalid_q, rvalid_d;
	word_t       rdata_q, rdata_d;
	axi_resp_t   rresp_q, rresp_d;
	logic        awready_q, awready_d, wready_q, wready_d;
	logic        arready_q, arready_d;

	// L1 exit timer
	l1_state_e   l1_state_q, l1_state_d;
	logic [15:0] l1_cnt_q, l1_cnt_d;
	logic        l1_done_q, l1_done_d;
	logic        exiting_q, exiting_d;

	word_t       lcap_word;
	wire word_t  wr_merged;
	logic [2:0]  l0s_lat;
	logic        do_write;

	always_comb begin
		l0s_lat = cmn_clk_q ? `L0S_COMMON : `L0S_SEPARATE;
		lcap_word = '0;
		lcap_word[`SPEED_MSB:`SPEED_LSB] = `SPEED_RESET;
		lcap_word[`WIDTH_MSB:`WIDTH_LSB] = width_q;
		lcap_word[`LPS_MSB:`LPS_LSB] = `LPS_RESET;
		lcap_word[`L0S_MSB:`L0S_LSB] = l0s_lat;
		lcap_word[`L1_MSB:`L1_LSB] = l1_lat_q;
		lcap_word[`CLKRM_BIT] = clkrm_q;
		lcap_word[`SDOWN_BIT] = sdown_q;
		lcap_word[`ACTREP_BIT] = active_rep_q;
		lcap_word[`RSVD_MSB:`RSVD_LSB] = 3'h0;
		lcap_word[`PORT_MSB:`PORT_LSB] = port_q;
	end

	for (genvar b = 0; b < 4; b++) begin : g_merge
		assign wr_merged[b * 8 +: 8] = w_strb_q[b] ? w_data_q[b * 8 +: 8] : lcap_word[b * 8 +: 8];
	end

	assign do_write = aw_have_q && w_have_q && !bvalid_q;

	always_comb begin
		init_d = 1'b1;
		width_d = width_q;
		l1_lat_d = l1_lat_q;
		clkrm_d = clkrm_q;
		sdown_d = sdown_q;
		active_rep_d = active_rep_q;
		port_d = port_q;
		upstream_d = upstream_q;
		cmn_clk_d = cmn_clk_q;
		unlock_d = unlock_q;
		if (!init_q) begin
			width_d = phys_width;
			port_d = port_number;
			upstream_d = is_upstream;
			sdown_d = !is_upstream;
			active_rep_d = !is_upstream;
		end else if (do_write) begin
			case (aw_addr_q)
				`LCAP_OFFSET: begin
					if (unlock_q) begin
						if (upstream_q) begin
							width_d = wr_merged[`WIDTH_MSB:`WIDTH_LSB];
						end
						l1_lat_d = wr_merged[`L1_MSB:`L1_LSB];
						clkrm_d = wr_merged[`CLKRM_BIT];
						sdown_d = wr_merged[`SDOWN_BIT] && !upstream_q;
						active_rep_d = wr_merged[`ACTREP_BIT] && !upstream_q;
					end
				end
				`LCTL_OFFSET: begin
					if (w_strb_q[0]) begin
						cmn_clk_d = w_data_q[`CMNCLK_BIT];
					end
				end
				`UNLOCK_OFFSET: begin
					if (w_strb_q[0]) begin
						unlock_d = w_data_q[`UNLOCK_BIT];
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		aw_have_d = aw_have_q;
		aw_addr_d = aw_addr_q;
		w_have_d = w_have_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_d = 1'b1;
			aw_addr_d = {s_axi_awaddr[11:2], 2'b00};
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		if (do_write) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			case (aw_addr_q)
				`LCAP_OFFSET, `LCTL_OFFSET, `UNLOCK_OFFSET, `LSTAT_OFFSET: bresp_d = `RESP_OKAY;
				default: bresp_d = `RESP_SLVERR;
			endcase
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d = `RESP_OKAY;
			case ({s_axi_araddr[11:2], 2'b00})
				`LCAP_OFFSET: rdata_d = lcap_word;
				`LCTL_OFFSET: rdata_d = word_t'({cmn_clk_q, 6'h00});
				`UNLOCK_OFFSET: rdata_d = word_t'(unlock_q);
				`LSTAT_OFFSET: rdata_d = word_t'({upstream_q, l1_state_q == L1_EXITING, train_width});
				default: begin
					rdata_d = '0;
					rresp_d = `RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		awready_d = !aw_have_d;
		wready_d = !w_have_d;
		arready_d = !rvalid_d;
	end

	always_comb begin
		l1_state_d = l1_state_q;
		l1_cnt_d = l1_cnt_q;
		l1_done_d = 1'b0;
		case (l1_state_q)
			L1_IDLE: begin
				if (l1_exit_req) begin
					l1_state_d = L1_EXITING;
					l1_cnt_d = 16'(L1_EXIT_CYCLES - 2);
				end
			end
			L1_EXITING: begin
				if (l1_cnt_q == 16'h0000) begin
					l1_state_d = L1_IDLE;
					l1_done_d = 1'b1;
				end else begin
					l1_cnt_d = l1_cnt_q - 16'h0001;
				end
			end
			default: l1_state_d = L1_IDLE;
		endcase
		exiting_d = (l1_state_d == L1_EXITING);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			init_q <= 1'b0;
			width_q <= `WIDTH_X1;
			l1_lat_q <= `L1_RESET;
			clkrm_q <= `CLKRM_RESET;
			sdown_q <= 1'b0;
			active_rep_q <= 1'b0;
			port_q <= 8'h00;
			upstream_q <= 1'b0;
			cmn_clk_q <= 1'b0;
			unlock_q <= 1'b0;
			aw_have_q <= 1'b0;
			aw_addr_q <= 12'h000;
			w_have_q <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= `RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= `RESP_OKAY;
			l1_state_q <= L1_IDLE;
			l1_cnt_q <= 16'h0000;
			l1_done_q <= 1'b0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			arready_q <= 1'b1;
			exiting_q <= 1'b0;
		end else begin
			init_q <= init_d;
			width_q <= width_d;
			l1_lat_q <= l1_lat_d;
			clkrm_q <= clkrm_d;
			sdown_q <= sdown_d;
			active_rep_q <= active_rep_d;
			port_q <= port_d;
			upstream_q <= upstream_d;
			cmn_clk_q <= cmn_clk_d;
			unlock_q <= unlock_d;
			aw_have_q <= aw_have_d;
			aw_addr_q <= aw_addr_d;
			w_have_q <= w_have_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			l1_state_q <= l1_state_d;
			l1_cnt_q <= l1_cnt_d;
			l1_done_q <= l1_done_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			arready_q <= arready_d;
			exiting_q <= exiting_d;
		end
	end

	lane_width_decode u_width (
		.clock       (clock),
		.rst         (rst),
		.width_field (width_q),
		.train_width (train_width)
	);

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign common_clock_config = cmn_clk_q;
	assign l1_exiting = exiting_q;
	assign l1_exit_done = l1_done_q;
endmodule

/* File: hdl/link_cap_cfg.svh */
// Offsets, field positions, reset values and timing for the link capabilities block
`ifndef LINK_CAP_CFG_SVH
`define LINK_CAP_CFG_SVH

`define LCAP_OFFSET        12'h04C
`define LCTL_OFFSET        12'h050
`define UNLOCK_OFFSET      12'h054
`define LSTAT_OFFSET       12'h058

`define SPEED_LSB          0
`define SPEED_MSB          3
`define WIDTH_LSB          4
`define WIDTH_MSB          9
`define LPS_LSB            10
`define LPS_MSB            11
`define L0S_LSB            12
`define L0S_MSB            14
`define L1_LSB             15
`define L1_MSB             17
`define CLKRM_BIT          18
`define SDOWN_BIT          19
`define ACTREP_BIT         20
`define RSVD_LSB           21
`define RSVD_MSB           23
`define PORT_LSB           24
`define PORT_MSB           31
`define CMNCLK_BIT         6
`define UNLOCK_BIT         0

`define SPEED_RESET        4'h1
`define LPS_RESET          2'h3
`define L0S_SEPARATE       3'h5
`define L0S_COMMON         3'h3
`define L1_RESET           3'h2
`define CLKRM_RESET        1'h0

`define WIDTH_X1           6'h01
`define WIDTH_X2           6'h02
`define WIDTH_X4           6'h04

`define CLOCK_MHZ          125
`define L1_EXIT_MAX_NS     2300
`define L1_EXIT_CYCLES     ((`L1_EXIT_MAX_NS * `CLOCK_MHZ) / 1000)

`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

/* File: hdl/link_cap_pkg.sv */
// Types shared by the link capabilities block
package link_cap_pkg;
	typedef logic [31:0] word_t;
	typedef logic [5:0]  lane_width_t;
	typedef logic [1:0]  axi_resp_t;
	typedef enum logic [0:0] {
		L1_IDLE,
		L1_EXITING
	} l1_state_e;
endpackage

/* File: hdl/lane_width_decode.sv */
// Maps the programmed width field onto the width the link really trains at
`include "link_cap_cfg.svh"
module lane_width_decode (
	input  wire logic                      clock,
	input  wire logic                      rst,
	input  wire link_cap_pkg::lane_width_t width_field,
	output link_cap_pkg::lane_width_t      train_width
);
	import link_cap_pkg::*;

	lane_width_t train_width_d;
	lane_width_t train_width_q;

	always_comb begin
		case (width_field)
			`WIDTH_X1: train_width_d = `WIDTH_X1;
			`WIDTH_X2: train_width_d = `WIDTH_X2;
			`WIDTH_X4: train_width_d = `WIDTH_X4;
			default: train_width_d = `WIDTH_X1;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			train_width_q <= `WIDTH_X1;
		end else begin
			train_width_q <= train_width_d;
		end
	end

	assign train_width = train_width_q;
endmodule

/* File: testbench/link_cap_asserts.sv */
// Port checks for the link capabilities register
`include "link_cap_cfg.svh"
module link_cap_asserts #(
	parameter int L1_EXIT_CYCLES = 4
) (
	input wire logic                      clock,
	input wire logic                      rst,
	input wire logic                      is_upstream,
	input wire logic [7:0]                port_number,
	input wire logic                      s_axi_arvalid,
	input wire logic                      s_axi_arready,
	input wire logic [11:0]               s_axi_araddr,
	input wire logic                      s_axi_rvalid,
	input wire link_cap_pkg::word_t       s_axi_rdata,
	input wire link_cap_pkg::lane_width_t train_width,
	input wire logic                      common_clock_config,
	input wire logic                      l1_exiting
);
	import link_cap_pkg::*;
	logic       cap_q, cap_d, hit;
	logic [9:0] cnt_q, cnt_d;
	// Read data is checked only when the taken address was the capabilities word
	assign hit = s_axi_rvalid && cap_q;
	always_comb begin
		cap_d = (s_axi_arvalid && s_axi_arready) ? ({s_axi_araddr[11:2], 2'h0} == `LCAP_OFFSET) : cap_q;
		cnt_d = l1_exiting ? cnt_q + 10'h001 : 10'h000;
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			{cap_q, cnt_q} <= 11'h000;
		else
			{cap_q, cnt_q} <= {cap_d, cnt_d};
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	property p_speed; hit |-> s_axi_rdata[3:0] == `SPEED_RESET; endproperty
	a_speed: assert property (p_speed) else $error("speed field wrong");
	property p_lps; hit |-> s_axi_rdata[11:10] == `LPS_RESET; endproperty
	a_lps: assert property (p_lps) else $error("low power support wrong");
	property p_l0s; hit |-> s_axi_rdata[14:12] == (common_clock_config ? `L0S_COMMON : `L0S_SEPARATE); endproperty
	a_l0s: assert property (p_l0s) else $error("l0s latency wrong");
	property p_rsvd; hit |-> s_axi_rdata[23:21] == 3'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
	property p_port; hit |-> s_axi_rdata[31:24] == port_number; endproperty
	a_port: assert property (p_port) else $error("port id wrong");
	property p_up; hit && is_upstream |-> s_axi_rdata[20:19] == 2'h0; endproperty
	a_up: assert property (p_up) else $error("upstream report bits set");
	property p_tw; train_width inside {`WIDTH_X1, `WIDTH_X2, `WIDTH_X4}; endproperty
	a_tw: assert property (p_tw) else $error("train width reserved");
	property p_l1; l1_exiting |-> cnt_q <= L1_EXIT_CYCLES; endproperty
	a_l1: assert property (p_l1) else $error("l1 exit too long");
endmodule

bind link_capabilities_register link_cap_asserts #(.L1_EXIT_CYCLES(L1_EXIT_CYCLES)) u_asserts (
	.clock, .rst, .is_upstream, .port_number, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
	.s_axi_rvalid, .s_axi_rdata, .train_width, .common_clock_config, .l1_exiting
);

/* File: testbench/link_capabilities_register_tb_top.sv */
// Self-checking bench for the link capabilities register
`include "link_cap_cfg.svh"
module link_capabilities_register_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import link_cap_pkg::*;
	localparam int L1 = 4;
	logic        clock, rst, is_upstream, common_clock_config, l1_exiting, l1_exit_done;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        l1_exit_req = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	logic        s_axi_bready = 1, s_axi_rready = 1;
	logic [7:0]  port_number;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	word_t       s_axi_wdata = 0, s_axi_rdata, rdat;
	axi_resp_t   s_axi_bresp, s_axi_rresp, rsp;
	lane_width_t phys_width, train_width;
	int          failures = 0;
	int          compares = 0;
	lane_width_t ws[6] = '{6'h01, 6'h02, 6'h04, 6'h03, 6'h00, 6'h08};
	lane_width_t te[6] = '{6'h01, 6'h02, 6'h04, 6'h01, 6'h01, 6'h01};

	link_capabilities_register #(.L1_EXIT_CYCLES(L1)) u_dut (
		.clock, .rst, .is_upstream, .port_number, .phys_width, .l1_exit_req,
		.s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
		.train_width, .common_clock_config, .l1_exiting, .l1_exit_done
	);

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	function automatic word_t cap(logic up, logic [7:0] pn, lane_width_t w, logic cc, logic [2:0] l1, logic cr);
		return {pn, 3'h0, ~up, ~up, cr, l1, (cc ? 3'h3 : 3'h5), 2'h3, w, 4'h1};
	endfunction

	task summarize;
		if (failures == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task chk(input string nm, input word_t seen, input word_t exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task tmo(input int k);
		if (k >= 40) begin
			chk("timeout", 32'(k), 32'h0);
			summarize();
		end
	endtask

	task rst_as(input logic up, input logic [7:0] pn, input lane_width_t w);
		rst <= 1'b1;
		is_upstream <= up;
		port_number <= pn;
		phys_width <= w;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
	endtask

	task wr(input logic [11:0] a, input word_t d);
		logic aw, w;
		int   k;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(posedge clock);
			if (!aw && !w && s_axi_bvalid === 1'b1)
				break;
			aw = aw && s_axi_awready !== 1'b1;
			w = w && s_axi_wready !== 1'b1;
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end
		rsp = s_axi_bresp;
		tmo(k);
	endtask

	task rd(input logic [11:0] a);
		logic ar;
		int   k;
		ar = 1'b1;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(posedge clock);
			if (!ar && s_axi_rvalid === 1'b1)
				break;
			ar = ar && s_axi_arready !== 1'b1;
			s_axi_arvalid <= ar;
		end
		rdat = s_axi_rdata;
		rsp = s_axi_rresp;
		tmo(k);
	endtask

	task rc(input logic [11:0] a, input word_t e);
		rd(a);
		chk("link_capabilities", rdat, e);
	endtask

	initial begin
		int n;
		rst_as(1'b0, 8'h03, 6'h04);
		rc(`LCAP_OFFSET, cap(1'b0, 8'h03, 6'h04, 1'b0, 3'h2, 1'b0));
		wr(`LCTL_OFFSET, 32'h0000_0040);
		chk("common_clock", 32'(common_clock_config), 32'h1);
		rd(`LCTL_OFFSET);
		chk("link_control", rdat, 32'h0000_0040);
		rc(`LCAP_OFFSET, cap(1'b0, 8'h03, 6'h04, 1'b1, 3'h2, 1'b0));
		wr(`LCAP_OFFSET, 32'hFFFF_FFFF);
		chk("bresp", 32'(rsp), 32'h0);
		rc(`LCAP_OFFSET, cap(1'b0, 8'h03, 6'h04, 1'b1, 3'h2, 1'b0));
		wr(`UNLOCK_OFFSET, 32'h0000_0001);
		rd(`UNLOCK_OFFSET);
		chk("unlock", rdat, 32'h0000_0001);
		wr(`LCAP_OFFSET, 32'hFFFF_FFFF);
		rc(`LCAP_OFFSET, cap(1'b0, 8'h03, 6'h04, 1'b1, 3'h7, 1'b1));
		wr(12'h100, 32'hFFFF_FFFF);
		chk("bresp", 32'(rsp), 32'(`RESP_SLVERR));
		rd(12'h100);
		chk("rresp", 32'(rsp), 32'(`RESP_SLVERR));
		chk("rdata", rdat, 32'h0);
		// One request pulse, then count cycles to the done pulse
		l1_exit_req <= 1'b1;
		@(posedge clock);
		l1_exit_req <= 1'b0;
		@(posedge clock);
		chk("l1_exiting", 32'(l1_exiting), 32'h1);
		for (n = 1; n < 40 && l1_exit_done !== 1'b1; n++)
			@(posedge clock);
		chk("l1_exit", 32'(n <= L1 + 1), 32'h1);
		tmo(n);
		rst_as(1'b1, 8'h00, 6'h02);
		rc(`LCAP_OFFSET, cap(1'b1, 8'h00, 6'h02, 1'b0, 3'h2, 1'b0));
		rd(`LSTAT_OFFSET);
		chk("link_status", rdat, 32'h0000_0082);
		wr(`UNLOCK_OFFSET, 32'h0000_0001);
		for (int i = 0; i < 6; i++) begin
			wr(`LCAP_OFFSET, 32'h0018_0000 | 32'(ws[i]) << 4);
			rc(`LCAP_OFFSET, cap(1'b1, 8'h00, ws[i], 1'b0, 3'h0, 1'b0));
			repeat (3) @(posedge clock);
			chk("train_width", 32'(train_width), 32'(te[i]));
		end
		summarize();
	end
endmodule
